//--- ssg_pkg.sv
// Package for the sequence start and general output logic
package ssg_pkg;
	localparam int NUM_CH = 16;
	localparam int NUM_PIN = 12;
	localparam int PAGE_W = 5;
	// Register offsets on the paged command port
	localparam logic [7:0] CMD_TIMEOUT = 8'hE6;
	localparam logic [7:0] CMD_SEQ_CFG = 8'hE8;
	localparam logic [7:0] CMD_PIN_CFG = 8'hE9;
	// Start configuration fields
	localparam int SEQ_GROUP_LSB = 0;
	localparam int SEQ_TRIG_LSB = 4;
	localparam int SIGNATURE_MATCH_FIELD_LSB = 8;
	localparam int SEQ_MASK_LSB = 16;
	localparam logic [31:0] SEQ_CFG_RW_MASK = 32'hFFFF_0F33;
	localparam logic [31:0] SEQ_CFG_RESET = 32'h0000_0000;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
	// Output pin configuration fields
	localparam int PIN_FUNC_LSB = 0;
	localparam int PIN_POL_BIT = 3;
	localparam int PIN_DRV_BIT = 4;
	localparam int PIN_MASK_LSB = 16;
	localparam logic [31:0] PIN_CFG_RESET = 32'h0000_0000;
	// Millisecond tick at 40 MHz
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
	typedef enum logic [1:0] {
		TRIG_GROUP = 2'b00,
		TRIG_AND = 2'b01,
		TRIG_MATCH = 2'b10,
		TRIG_RSVD = 2'b11
	} ssg_trig_t;
	typedef enum logic [2:0] {
		FN_MARGIN = 3'b000,
		FN_FORCE_ON = 3'b001,
		FN_FORCE_OFF = 3'b010,
		FN_AND = 3'b011,
		FN_OR_ALARM = 3'b100
	} ssg_pin_fn_t;
	// One register access on the command port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [PAGE_W-1:0] page;
		logic [7:0] cmd;
		logic [31:0] wdata;
	} ssg_req_t;
	// Per-channel supervisor report
	typedef struct packed {
		logic start;
		logic timeout;
	} ssg_evt_t;
endpackage : ssg_pkg

//--- ssg_cfg_mem.sv
// Small register memory, one word per page, registered read
`timescale 1ns/100ps
module ssg_cfg_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 32,
	parameter int AW = 4
) (
	// Clock
	input wire logic clk_sys_in,
	// Write port
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	// Read port
	input wire logic [AW-1:0] raddr_in,
	output logic [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk_sys_in)
	begin
		if (we_in)
		begin
			mem_q[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		rdata_out <= mem_q[raddr_in];
	end
endmodule // ssg_cfg_mem

//--- ssg_core.sv
// Sequence start selection, start timeout supervisor and output pin logic
`timescale 1ns/100ps
module ssg_core (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Paged command port
	input wire ssg_pkg::ssg_req_t req_in,
	output logic [31:0] rdata_out,
	output logic rvalid_out,
	// Sequencing group signals and signature pin decode
	input wire logic [3:0] group_start_in,
	input wire logic [3:0] signature_code_in,
	// Channel inputs
	input wire logic [ssg_pkg::NUM_CH-1:0] goodness_in,
	input wire logic [ssg_pkg::NUM_CH-1:0] alarm_in,
	input wire logic alert_enable_in,
	// Margining request per pin
	input wire logic [ssg_pkg::NUM_PIN-1:0] margin_drive_in,
	// Channel results
	output logic [ssg_pkg::NUM_CH-1:0] chan_start_out,
	output logic [ssg_pkg::NUM_CH-1:0] vout_summary_out,
	output logic [ssg_pkg::NUM_CH-1:0] start_timeout_fault_bit_out,
	output logic [ssg_pkg::NUM_CH-1:0] fault_action_out,
	output logic alert_out,
	// Output pins
	output logic [ssg_pkg::NUM_PIN-1:0] gpo_out,
	output logic [ssg_pkg::NUM_PIN-1:0] gpo_oe_out,
	output logic [ssg_pkg::NUM_PIN-1:0] margin_mode_out
);
	localparam int NC = ssg_pkg::NUM_CH;
	localparam int NP = ssg_pkg::NUM_PIN;

	// Synchronised pins
	logic [3:0] grp_s1_q, grp_s2_q, sig_s1_q, sig_s2_q;
	logic [NC-1:0] good_s1_q, good_s2_q, alm_s1_q, alm_s2_q;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			grp_s1_q <= 4'h0;
			grp_s2_q <= 4'h0;
			sig_s1_q <= 4'h0;
			sig_s2_q <= 4'h0;
			good_s1_q <= 16'h0000;
			good_s2_q <= 16'h0000;
			alm_s1_q <= 16'h0000;
			alm_s2_q <= 16'h0000;
		end
		else
		begin
			grp_s1_q <= group_start_in;
			grp_s2_q <= grp_s1_q;
			sig_s1_q <= signature_code_in;
			sig_s2_q <= sig_s1_q;
			good_s1_q <= goodness_in;
			good_s2_q <= good_s1_q;
			alm_s1_q <= alarm_in;
			alm_s2_q <= alm_s1_q;
		end
	end

	// Config registers held as flops so every channel is read at once
	logic [15:0] timeout_q [NC];
	logic [31:0] seq_cfg_q [NC];
	logic [31:0] pin_cfg_q [NP];
	logic pg_ok;
	assign pg_ok = req_in.page < 5'(NC);

	// Millisecond tick
	logic [15:0] ms_cnt_q;
	logic ms_tick_q;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ms_cnt_q <= 16'h0000;
			ms_tick_q <= 1'b0;
		end
		else if (ms_cnt_q == 16'(ssg_pkg::MS_CYCLES - 1))
		begin
			ms_cnt_q <= 16'h0000;
			ms_tick_q <= 1'b1;
		end
		else
		begin
			ms_cnt_q <= ms_cnt_q + 16'h0001;
			ms_tick_q <= 1'b0;
		end
	end

	// Read mirror in the memory so reads come out of a register
	logic [31:0] mem_wdata, mem_rdata;
	logic mem_we;
	logic [3:0] mem_waddr;
	always_comb
	begin
		mem_we = 1'b0;
		mem_waddr = req_in.page[3:0];
		mem_wdata = 32'h0000_0000;
		if (req_in.wr && req_in.cmd == ssg_pkg::CMD_SEQ_CFG && pg_ok)
		begin
			mem_we = 1'b1;
			mem_wdata = req_in.wdata & ssg_pkg::SEQ_CFG_RW_MASK;
		end
	end

	ssg_cfg_mem #(.DEPTH(16), .WIDTH(32), .AW(4)) u_seq_mirror (
		.clk_sys_in(clk_sys_in),
		.we_in(mem_we),
		.waddr_in(mem_waddr),
		.wdata_in(mem_wdata),
		.raddr_in(req_in.page[3:0]),
		.rdata_out(mem_rdata)
	);

	logic [31:0] rd_other_q;
	logic rd_seq_q;
	logic rd_seq_wr_q;
	logic [NC-1:0] seq_wr_q;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rd_other_q <= 32'h0000_0000;
			rd_seq_q <= 1'b0;
			rd_seq_wr_q <= 1'b0;
			rvalid_out <= 1'b0;
		end
		else
		begin
			rvalid_out <= req_in.rd;
			rd_seq_q <= req_in.rd && req_in.cmd == ssg_pkg::CMD_SEQ_CFG && pg_ok;
			rd_seq_wr_q <= seq_wr_q[req_in.page[3:0]];
			rd_other_q <= 32'h0000_0000;
			if (req_in.rd && req_in.cmd == ssg_pkg::CMD_TIMEOUT && pg_ok)
			begin
				rd_other_q <= {16'h0000, timeout_q[req_in.page[3:0]]};
			end
			else if (req_in.rd && req_in.cmd == ssg_pkg::CMD_PIN_CFG && req_in.page < 5'(NP))
			begin
				rd_other_q <= pin_cfg_q[req_in.page[3:0]];
			end
		end
	end
	// Memory output is registered, so the mux is its second stage
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rdata_out <= 32'h0000_0000;
		end
		else
		begin
			rdata_out <= rd_seq_q ? (rd_seq_wr_q ? mem_rdata : ssg_pkg::SEQ_CFG_RESET) : rd_other_q;
		end
	end

	// The mirror has no reset, so a page never written must read its reset value
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			seq_wr_q <= 16'h0000;
		end
		else if (mem_we)
		begin
			seq_wr_q[mem_waddr] <= 1'b1;
		end
	end

	logic alert_d;
	always_comb
	begin
		alert_d = 1'b0;
		for (int i = 0; i < NC; i++)
		begin
			alert_d = alert_d | start_timeout_fault_bit_out[i];
		end
		alert_d = alert_d & alert_enable_in;
	end
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			alert_out <= 1'b0;
		end
		else
		begin
			alert_out <= alert_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NC; g++)
		begin : g_ch
			logic [31:0] c;
			logic trig, grp_seen_q, busy_q;
			logic [15:0] ms_q;
			ssg_pkg::ssg_trig_t tsel;
			logic [15:0] amask;
			assign c = seq_cfg_q[g];
			assign tsel = ssg_pkg::ssg_trig_t'(c[ssg_pkg::SEQ_TRIG_LSB +: 2]);
			assign amask = c[ssg_pkg::SEQ_MASK_LSB +: 16];
			always_comb
			begin
				case (tsel)
					ssg_pkg::TRIG_GROUP: trig = grp_s2_q[c[ssg_pkg::SEQ_GROUP_LSB +: 2]];
					ssg_pkg::TRIG_AND: trig = &(good_s2_q | ~amask);
					ssg_pkg::TRIG_MATCH: trig = (c[ssg_pkg::SIGNATURE_MATCH_FIELD_LSB +: 4] != 4'h0)
						&& (sig_s2_q == c[ssg_pkg::SIGNATURE_MATCH_FIELD_LSB +: 4]);
					default: trig = 1'b0;
				endcase
			end
			always_ff @(posedge clk_sys_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					timeout_q[g] <= ssg_pkg::TIMEOUT_RESET;
					seq_cfg_q[g] <= ssg_pkg::SEQ_CFG_RESET;
				end
				else if (req_in.wr && pg_ok && req_in.page[3:0] == 4'(g))
				begin
					if (req_in.cmd == ssg_pkg::CMD_TIMEOUT)
					begin
						timeout_q[g] <= req_in.wdata[15:0];
					end
					if (req_in.cmd == ssg_pkg::CMD_SEQ_CFG)
					begin
						seq_cfg_q[g] <= req_in.wdata & ssg_pkg::SEQ_CFG_RW_MASK;
					end
				end
			end
			// Timeout runs from the selected group rising until this channel starts
			always_ff @(posedge clk_sys_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					busy_q <= 1'b0;
					grp_seen_q <= 1'b0;
					ms_q <= 16'h0000;
					chan_start_out[g] <= 1'b0;
					vout_summary_out[g] <= 1'b0;
					start_timeout_fault_bit_out[g] <= 1'b0;
					fault_action_out[g] <= 1'b0;
				end
				else
				begin
					grp_seen_q <= grp_s2_q[c[1:0]];
					chan_start_out[g] <= trig;
					fault_action_out[g] <= 1'b0;
					if (trig)
					begin
						busy_q <= 1'b0;
						ms_q <= 16'h0000;
					end
					else if (grp_s2_q[c[1:0]] && !grp_seen_q)
					begin
						busy_q <= (timeout_q[g] != 16'h0000);
						ms_q <= 16'h0000;
					end
					else if (busy_q && ms_tick_q)
					begin
						if (ms_q + 16'h0001 >= timeout_q[g])
						begin
							busy_q <= 1'b0;
							vout_summary_out[g] <= 1'b1;
							start_timeout_fault_bit_out[g] <= 1'b1;
							fault_action_out[g] <= 1'b1;
						end
						else
						begin
							ms_q <= ms_q + 16'h0001;
						end
					end
				end
			end
		end
		for (g = 0; g < NP; g++)
		begin : g_pin
			logic [31:0] p;
			logic act;
			logic [15:0] m;
			assign p = pin_cfg_q[g];
			assign m = p[ssg_pkg::PIN_MASK_LSB +: 16];
			always_comb
			begin
				case (ssg_pkg::ssg_pin_fn_t'(p[ssg_pkg::PIN_FUNC_LSB +: 3]))
					ssg_pkg::FN_FORCE_ON: act = 1'b1;
					ssg_pkg::FN_FORCE_OFF: act = 1'b0;
					ssg_pkg::FN_AND: act = &(good_s2_q | ~m);
					ssg_pkg::FN_OR_ALARM: act = |(alm_s2_q & m);
					default: act = 1'b0;
				endcase
			end
			always_ff @(posedge clk_sys_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					pin_cfg_q[g] <= ssg_pkg::PIN_CFG_RESET;
				end
				else if (req_in.wr && req_in.cmd == ssg_pkg::CMD_PIN_CFG && req_in.page == 5'(g))
				begin
					pin_cfg_q[g] <= req_in.wdata;
				end
			end
			always_ff @(posedge clk_sys_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					gpo_out[g] <= 1'b0;
					gpo_oe_out[g] <= 1'b0;
					margin_mode_out[g] <= 1'b1;
				end
				else
				begin
					margin_mode_out[g] <= (p[2:0] == 3'b000);
					if (p[2:0] == 3'b000)
					begin
						gpo_out[g] <= margin_drive_in[g];
						gpo_oe_out[g] <= 1'b0;
					end
					else
					begin
						gpo_out[g] <= act ~^ p[ssg_pkg::PIN_POL_BIT];
						// Open drain only drives the low level
						gpo_oe_out[g] <= !p[ssg_pkg::PIN_DRV_BIT] || !(act ~^ p[ssg_pkg::PIN_POL_BIT]);
					end
				end
			end
		end
	endgenerate

	// Checks
	timeout_sets_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		$rose(start_timeout_fault_bit_out[4]) |-> vout_summary_out[4] && fault_action_out[4])
		else $error("timeout without summary");
	zero_disable_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		timeout_q[5] == 16'h0000 && $stable(timeout_q[5]) |=> !$rose(g_ch[5].busy_q))
		else $error("zero timeout armed");
	start_clears_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		g_ch[6].trig |=> !g_ch[6].busy_q && g_ch[6].ms_q == 16'h0000)
		else $error("start did not clear");
	alert_gate_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		!alert_enable_in |=> !alert_out)
		else $error("alert while disabled");
	rsvd_trig_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		seq_cfg_q[13][5:4] == 2'b11 |=> !chan_start_out[13])
		else $error("reserved code started");
	seq_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(seq_cfg_q[1] & ~ssg_pkg::SEQ_CFG_RW_MASK) == 32'h0000_0000)
		else $error("unused bits set");
	force_on_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		pin_cfg_q[1][4:0] == 5'b01001 |=> gpo_out[1] && gpo_oe_out[1])
		else $error("force on wrong");
	or_alarm_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		pin_cfg_q[4][2:0] == 3'b100 && pin_cfg_q[4][3] && (alm_s2_q & pin_cfg_q[4][31:16]) != 16'h0000
		|=> gpo_out[4])
		else $error("alarm or wrong");
	read_lat_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		req_in.rd |=> rvalid_out)
		else $error("read answer late");
	timeout_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		$rose(start_timeout_fault_bit_out[4]));
	start_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(chan_start_out[2]));
	pin_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(gpo_out[3]));
endmodule // ssg_core

//--- ssg_supply_model.sv
// Power supply model: each channel reports power good a fixed lag after it is started
`timescale 1ns/100ps
module ssg_supply_model #(
	parameter int LAG = 4
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Channel start requests and power good replies
	input wire logic [15:0] start_in,
	output logic [15:0] good_out
);
	logic [LAG*16-1:0] dly_q;

	// A supply needs time to ramp, so power good never follows its start in the same cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			dly_q <= '0;
		else
			dly_q <= {dly_q[LAG*16-17:0], start_in};
	end

	assign good_out = dly_q[LAG*16-1 -: 16];
endmodule // ssg_supply_model

//--- ssg_core_tb.sv
// Testbench for the sequence start and output pin logic
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module ssg_core_tb;
	logic clk_sys_in;
	logic arst_n_in;
	ssg_pkg::ssg_req_t req;
	logic [31:0] rdata;
	logic rvalid;
	logic [3:0] grp;
	logic [3:0] sig;
	logic [15:0] good;
	logic [15:0] alarm;
	logic alert_en;
	logic [11:0] mdrive;
	logic [15:0] start;
	logic [15:0] summary;
	logic [15:0] fault;
	logic [15:0] action;
	logic alert;
	logic [11:0] gpo;
	logic [11:0] oe;
	logic [11:0] mmode;
	int fails;
	int samples_checked;
	int act_cnt;
	logic [15:0] act_seen;

	ssg_core i_ssg_core (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.req_in(req),
		.rdata_out(rdata),
		.rvalid_out(rvalid),
		.group_start_in(grp),
		.signature_code_in(sig),
		.goodness_in(good),
		.alarm_in(alarm),
		.alert_enable_in(alert_en),
		.margin_drive_in(mdrive),
		.chan_start_out(start),
		.vout_summary_out(summary),
		.start_timeout_fault_bit_out(fault),
		.fault_action_out(action),
		.alert_out(alert),
		.gpo_out(gpo),
		.gpo_oe_out(oe),
		.margin_mode_out(mmode)
	);

	ssg_supply_model #(.LAG(4)) i_ssg_supply_model (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.start_in(start),
		.good_out(good)
	);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// Fault action is a one-cycle pulse, so it is counted as it happens
	always @(negedge clk_sys_in)
	begin
		if (arst_n_in === 1'b1 && action !== 16'h0000)
		begin
			act_cnt++;
			act_seen |= action;
		end
	end

	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	task automatic wr(input logic [4:0] pg, input logic [7:0] cmd, input logic [31:0] d);
		@(negedge clk_sys_in);
		req = '{wr: 1'b1, rd: 1'b0, page: pg, cmd: cmd, wdata: d};
		@(negedge clk_sys_in);
		req = '0;
	endtask

	// Valid answers one cycle after the strobe and data one cycle later, each for one cycle only
	task automatic rd(input logic [4:0] pg, input logic [7:0] cmd, input logic [31:0] e, input string n);
		@(negedge clk_sys_in);
		req = '{wr: 1'b0, rd: 1'b1, page: pg, cmd: cmd, wdata: 32'h0000_0000};
		@(negedge clk_sys_in);
		req = '0;
		`CHK("read valid", 1'b1, rvalid)
		@(negedge clk_sys_in);
		`CHK(n, e, rdata)
	endtask

	initial
	begin
		#3_000_000;
		fails++;
		tally_and_finish();
	end

	initial
	begin
		int i;
		arst_n_in = 1'b0;
		req = '0;
		grp = 4'h0;
		sig = 4'h0;
		alarm = 16'h0000;
		alert_en = 1'b1;
		mdrive = 12'h001;
		fails = 0;
		samples_checked = 0;
		act_cnt = 0;
		act_seen = 16'h0000;
		settle(16);
		arst_n_in = 1'b1;
		rd(5'd3, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0000, "seq reset");
		rd(5'd3, ssg_pkg::CMD_TIMEOUT, 32'h0000_0000, "timeout reset");
		rd(5'd3, ssg_pkg::CMD_PIN_CFG, 32'h0000_0000, "pin reset");
		wr(5'd13, ssg_pkg::CMD_SEQ_CFG, 32'hFFFF_FFFF);
		rd(5'd13, ssg_pkg::CMD_SEQ_CFG, 32'hFFFF_0F33, "seq unused");
		wr(5'd14, ssg_pkg::CMD_TIMEOUT, 32'h0000_ABCD);
		rd(5'd14, ssg_pkg::CMD_TIMEOUT, 32'h0000_ABCD, "timeout word");
		rd(5'd0, 8'hE7, 32'h0000_0000, "unmapped");
		// Everything is configured before any supply runs
		wr(5'd13, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0000);
		wr(5'd1, ssg_pkg::CMD_SEQ_CFG, 32'h0001_0010);
		wr(5'd2, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0520);
		wr(5'd3, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0020);
		wr(5'd8, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0020);
		wr(5'd4, ssg_pkg::CMD_SEQ_CFG, 32'h0100_0011);
		wr(5'd5, ssg_pkg::CMD_SEQ_CFG, 32'h0100_0011);
		wr(5'd6, ssg_pkg::CMD_SEQ_CFG, 32'h0001_0011);
		wr(5'd9, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0001);
		wr(5'd10, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0002);
		wr(5'd11, ssg_pkg::CMD_SEQ_CFG, 32'h0000_0003);
		wr(5'd4, ssg_pkg::CMD_TIMEOUT, 32'h0000_0001);
		wr(5'd6, ssg_pkg::CMD_TIMEOUT, 32'h0000_0001);
		wr(5'd1, ssg_pkg::CMD_PIN_CFG, 32'h0000_0009);
		wr(5'd2, ssg_pkg::CMD_PIN_CFG, 32'h0000_000A);
		wr(5'd3, ssg_pkg::CMD_PIN_CFG, 32'h0001_0003);
		wr(5'd4, ssg_pkg::CMD_PIN_CFG, 32'h0004_001C);
		settle(8);
		`CHK("margin mode", 12'hFE1, mmode)
		`CHK("pin level", 3'b101, gpo[3:1])
		`CHK("pin enable", 4'b1111, oe[4:1])
		`CHK("margin pin", 2'b01, {oe[0], gpo[0]})
		alarm = 16'h0008;
		settle(8);
		`CHK("masked alarm", 1'b1, oe[4])
		alarm = 16'h000C;
		settle(8);
		`CHK("alarm or", 1'b0, oe[4])
		`CHK("alarm level", 1'b1, gpo[4])
		sig = 4'h4;
		settle(8);
		`CHK("start sig four", 16'h0000, start)
		sig = 4'h5;
		settle(8);
		`CHK("start sig five", 16'h0004, start)
		grp = 4'b0100;
		settle(8);
		`CHK("start group two", 16'h0404, start)
		`CHK("alert idle", 1'b0, alert)
		grp = 4'b1111;
		settle(24);
		`CHK("start all", 16'hFEC7, start)
		`CHK("pin and", 1'b0, gpo[3])
		for (i = 0; i < 45000 && fault[4] !== 1'b1; i++)
			@(negedge clk_sys_in);
		settle(4);
		`CHK("fault bits", 16'h0010, fault)
		`CHK("summary bits", 16'h0010, summary)
		`CHK("action pulses", 1, act_cnt)
		`CHK("action channel", 16'h0010, act_seen)
		`CHK("alert on", 1'b1, alert)
		alert_en = 1'b0;
		settle(4);
		`CHK("alert gated", 1'b0, alert)
		tally_and_finish();
	end
endmodule // ssg_core_tb
